// [verif/tpc_master.sv]
// Bus master model on open-drain SCL and SDA.
// Assumes bench pull-ups; T is half an SCL period.
`timescale 1ns/1ps
`default_nettype none
module tpc_master (
    // Open-drain bus
    output logic      scl_low_o,
    output logic      sda_low_o,
    input  wire logic sda_i
);
    localparam int T = 200;
    initial {scl_low_o, sda_low_o} = 2'b00;
    // Also a repeated start
    task automatic start();
        #T scl_low_o = 0;
        #T sda_low_o = 1;
        #T scl_low_o = 1;
    endtask
    // SDA goes low T/4 after SCL falls and is released T after SCL rises
    task automatic stop();
        #(T/4) sda_low_o = 1;
        #T scl_low_o = 0;
        #T sda_low_o = 0;
    endtask
    // MSB first; bit 0 is the ACK slot
    task automatic xfer(input logic [8:0] w, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            #(T/4) sda_low_o = ~w[i];
            #(T*3/4) scl_low_o = 0;
            #T r[i] = sda_i;
            scl_low_o = 1;
        end
    endtask
endmodule
`default_nettype wire

// [verif/tpc_top_tb.sv]
// Bench: master model on the bus, expected enables and FIFO bytes.
// Assumes pull-ups on both bus lines; idle limit cut to 40.
`timescale 1ns/1ps
`default_nettype none
module tpc_top_tb;
    import tpc_pkg::*;
    logic       clk = 0, rst_n = 0, lclk = 0, pre = 0, dat = 0, stp = 0;
    logic       msc, msd, so, soe, sdoe, xo, pll, pa, push;
    logic [7:0] fd, b0, q[$];
    logic [8:0] r;
    int         num_errors = 0, total_checks = 0, seed = 32'h33491015;
    wire logic  scl = soe ? so : ~msc;
    wire logic  sda = ~(msd | sdoe);
    always #12.5 clk = ~clk;
    always #16 lclk = ~lclk;
    tpc_top #(.IDLE_CYCLES(40)) uut (.clock_i(clk), .rst_n_i(rst_n),
        .link_clk_i(lclk), .preset_mode_i(pre), .data_i(dat), .scl_i(scl),
        .scl_o(so), .scl_oe_o(soe), .sda_i(sda), .sda_o(), .sda_oe_o(sdoe),
        .pll_lock_i(1'b1), .tx_stop_i(stp), .xo_en_o(xo), .pll_en_o(pll),
        .pa_en_o(pa), .fifo_push_o(push), .fifo_data_o(fd));
    tpc_master mst (.scl_low_o(msc), .sda_low_o(msd), .sda_i(sda));
    // ==========================================
    // Checks and bus transactions
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) num_errors++;
        if (s !== e) $display("mismatch at %0t: %h not %h", $time, s, e);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Enables lag an event by a few cycles; 20 leaves margin
    task automatic pw(input logic [2:0] e);
        repeat (20) @(posedge clk);
        #1 chk({5'h00, xo, pll, pa}, {5'h00, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d[]);
        mst.start();
        mst.xfer({SLAVE_ADDR, 2'b01}, r);
        mst.xfer({a, 1'b1}, r);
        foreach (d[i]) mst.xfer({d[i], 1'b1}, r);
        mst.stop();
    endtask
    // Pointer write, repeated start, one byte read with NACK
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        mst.start();
        mst.xfer({SLAVE_ADDR, 2'b01}, r);
        mst.xfer({a, 1'b1}, r);
        mst.start();
        mst.xfer({SLAVE_ADDR, 2'b11}, r);
        mst.xfer(9'h1FF, r);
        d = r[8:1];
        mst.stop();
    endtask
    // Push is launched on the rising edge; look at it half a cycle later
    always @(negedge clk)
        if (push === 1'b1) chk(fd, q.pop_front());
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1;
        wr(ADDR_INIT_GUARD, '{INIT_GUARD_RST});
        wr(ADDR_CONFIG_FOUR, '{{6'h00, PDN_PROG}});
        pw(3'b110);
        rd(ADDR_CONFIG_FOUR, b0);
        chk(b0, {6'h00, PDN_PROG});
        wr(ADDR_TX_DATA, '{8'h5A});
        wr(ADDR_CONFIG_SEVEN, '{8'h04});
        pw(3'b111);
        b0 = $random(seed);
        q = '{b0, ~b0};
        wr(ADDR_TX_DATA, '{b0, ~b0});
        chk(8'(q.size()), 8'h00);
        @(posedge clk);
        #1 stp = 1;
        pw(3'b110);
        wr(ADDR_CONFIG_SEVEN, '{8'h04});
        pw(3'b111);
        @(posedge clk);
        #1 {pre, stp, rst_n} = 3'b100;
        repeat (10) @(posedge clk);
        #1 rst_n = 1;
        repeat (4) pw(3'b000);
        chk({7'h00, soe}, 8'h01);
        dat = 1;
        pw(3'b110);
        dat = 0;
        pw(3'b111);
        // Idle limit of 40 plus sync lag runs past one 20-cycle wait
        repeat (20) @(posedge clk);
        pw(3'b000);
        summarize();
    end
    initial begin
        #2000000 num_errors++;
        summarize();
    end
endmodule
`default_nettype wire

// [verilog/tpc_pkg.sv]
// Constants, types and carriers for the transmit power-state controller.
// Assumes a 40 MHz system clock and a separate link sampling clock.
`default_nettype none
package tpc_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ         = 40_000_000;
    localparam int TIMEBASE_HZ    = 3_200_000;
    localparam int BUFFERED_CLOCK_OUT_HZ      = 800_000;
    localparam int IDLE_TB_CYCLES = 4096;

    function automatic int ceil_div(input int num, input int den);
        return (num + den - 1) / den;
    endfunction

    // Least idle time, rounded up to system cycles
    localparam int PRESET_IDLE_CYC =
        ceil_div(IDLE_TB_CYCLES * (CLK_HZ / 100), TIMEBASE_HZ / 100);
    localparam int BUFFERED_CLOCK_OUT_HALF = CLK_HZ / (2 * BUFFERED_CLOCK_OUT_HZ);

    // ==========================================================
    // Bus address and register map
    // ==========================================================
    localparam logic [6:0] SLAVE_ADDR      = 7'h69;
    localparam int         REG_COUNT       = 20;
    localparam logic [7:0] ADDR_CONFIG_TWO = 8'h01;
    localparam logic [7:0] ADDR_CONFIG_FOUR = 8'h03;
    localparam logic [7:0] ADDR_CONFIG_SIX = 8'h0A;
    localparam logic [7:0] ADDR_CONFIG_SEVEN = 8'h10;
    localparam logic [7:0] ADDR_TX_DATA    = 8'h13;
    localparam logic [7:0] ADDR_INIT_GUARD = 8'h1A;
    localparam logic [7:0] CONFIG_TWO_RST  = 8'h80;
    localparam logic [7:0] INIT_GUARD_RST  = 8'h80;
    localparam int         TXEN_BIT        = 2;
    localparam int         DELAY_MSB       = 7;
    localparam int         DELAY_LSB       = 6;
    localparam int         PDN_MSB         = 1;
    localparam int         PDN_LSB         = 0;
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

    localparam logic [1:0] PDN_SHUT = 2'h0;
    localparam logic [1:0] PDN_STBY = 2'h1;
    localparam logic [1:0] PDN_PROG = 2'h2;

    typedef logic [REG_COUNT-1:0][7:0] tpc_regs_t;

    typedef enum {PW_SHUT, PW_WARM, PW_STBY, PW_PROG, PW_TX} tpc_power_t;
    typedef enum {BS_IDLE, BS_ADDR, BS_ADDR_ACK, BS_REG, BS_REG_ACK,
                  BS_WDATA, BS_WACK, BS_RDATA, BS_RACK} tpc_bus_t;

    // Link-side state
    typedef struct packed {
        tpc_bus_t   bus;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic       rd;
        logic [7:0] ptr;
        logic       woke;
        logic       sda_oe;
        logic       txen;
        logic       wake_tgl;
        logic       start_tgl;
        logic       push_tgl;
        logic [7:0] push_data;
        logic       clr_seen;
        logic       scl_d;
        logic       sda_d;
        tpc_regs_t  regs;
        logic [7:0] guard;
    } tpc_link_t;

    // System-side state
    typedef struct packed {
        tpc_power_t  state;
        logic [15:0] idle_cnt;
        logic        data_d;
        logic        wake_d;
        logic        start_d;
        logic        push_d;
        logic        stop_d;
        logic        clr_tgl;
        logic [6:0]  dly_cnt;
        logic [4:0]  clk_cnt;
        logic        buffered_clock_out;
        logic        clk_oe;
        logic        xo_en;
        logic        pll_en;
        logic        pa_en;
        logic        push;
        logic [7:0]  push_data;
    } tpc_core_t;

endpackage
`default_nettype wire

// [verilog/tpc_sync.sv]
// Two-flop synchroniser for levels and toggles.
// Assumes the destination clock samples slowly changing or toggle data.
`timescale 1ns/1ps
`default_nettype none
module tpc_sync #(
    parameter int W = 1
) (
    // Destination clock
    input  wire logic         clk_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic [W-1:0]      q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i) begin
        meta <= d_i;
        q_o  <= meta;
    end
endmodule
`default_nettype wire

// [verilog/tpc_top.sv]
// Power-state, clock-out and serial register control of the transmitter.
// Assumes open-drain bus pins resolved outside; link_clk_i oversamples them.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RULE_01] Master sets pointer, repeated start, reads
// [RULE_02] Read data MSB first, ACK continues
// [RULE_03] Read stays open until STOP
// [RULE_04] Preset drives 800 kHz clock; bus uses SCL
// [RULE_05] Clock delay field only in preset mode
// [RULE_06] Preset: rise warms, falling after lock transmits
// [RULE_07] Preset: 4096 idle timebase cycles shut down
// [RULE_08] Bus mode four power states
// [RULE_09] Own address wakes from standby or shutdown
// [RULE_10] No programming while standby or shutdown
// [RULE_11] Start edge from two aliased enable bits
// [RULE_12] Enable cleared on wake and return; code clears it on wake from shutdown only, not on wake from standby
// [RULE_13] Data register writes push, no increment
// [RULE_14] Stop flag selects next power state
// [RULE_15] Master writes guard then twenty registers
// [RULE_16] Master sends eight-bit dummy packet
// [RULE_17] Combined initialisation transaction accepted
// [RULE_18] Enter selected state, retain configuration
// [RULE_19] Master waits oscillator plus synthesizer time
// [RULE_20] Single transaction spacing 162 clocks
// [RULE_21] Leading burst read sized for warm-up
// [RULE_22] Standby start gives at least 72 clocks
// [RULE_23] Data pushes only in transmitter-enabled state
// [RULE_24] Stop flag rise disables transmitter
// [RULE_25] Mode value two returns to programming
module tpc_top import tpc_pkg::*; #(
    parameter int IDLE_CYCLES = PRESET_IDLE_CYC
) (
    // System clock and reset
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    // Link sampling clock
    input  wire logic link_clk_i,
    // Pins
    input  wire logic preset_mode_i,
    input  wire logic data_i,
    input  wire logic scl_i,
    output logic      scl_o,
    output logic      scl_oe_o,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    // Analog and transmit datapath status
    input  wire logic pll_lock_i,
    input  wire logic tx_stop_i,
    // Power enables
    output logic      xo_en_o,
    output logic      pll_en_o,
    output logic      pa_en_o,
    // Transmit FIFO write side
    output logic       fifo_push_o,
    output logic [7:0] fifo_data_o
);
    localparam logic [15:0] IDLE_LAST = 16'(IDLE_CYCLES - 1);

    tpc_link_t l;
    tpc_link_t next_l;
    tpc_core_t c;
    tpc_core_t next_c;

    // ==========================================================
    // Domain crossings
    // ==========================================================
    logic       link_rst_n;
    logic       scl_s;
    logic       sda_s;
    logic       lk_preset;
    logic       lk_shut;
    logic       lk_sleep;
    logic       lk_prog;
    logic       lk_tx;
    logic       lk_clr;
    logic       data_s;
    logic       lock_s;
    logic       preset_s;
    logic       wake_s;
    logic       start_s;
    logic       push_s;
    logic [3:0] cfg_s;

    tpc_sync #(.W(1)) u_lrst (.clk_i(link_clk_i), .d_i(rst_n_i),
                              .q_o(link_rst_n));
    tpc_sync #(.W(2)) u_lpin (.clk_i(link_clk_i), .d_i({scl_i, sda_i}),
                              .q_o({scl_s, sda_s}));
    // Power-state levels are stable for many link cycles
    tpc_sync #(.W(6)) u_lst (
        .clk_i(link_clk_i),
        .d_i({preset_s, c.state == PW_SHUT,
              c.state == PW_SHUT || c.state == PW_STBY,
              c.state == PW_PROG, c.state == PW_TX, c.clr_tgl}),
        .q_o({lk_preset, lk_shut, lk_sleep, lk_prog, lk_tx, lk_clr}));
    tpc_sync #(.W(3)) u_cpin (.clk_i(clock_i),
                              .d_i({data_i, pll_lock_i, preset_mode_i}),
                              .q_o({data_s, lock_s, preset_s}));
    tpc_sync #(.W(3)) u_cev (.clk_i(clock_i),
                             .d_i({l.wake_tgl, l.start_tgl, l.push_tgl}),
                             .q_o({wake_s, start_s, push_s}));
    // Configuration is quasi-static; a change may land over two cycles
    tpc_sync #(.W(4)) u_ccfg (
        .clk_i(clock_i),
        .d_i({l.regs[ADDR_CONFIG_TWO[4:0]][DELAY_MSB:DELAY_LSB],
              l.regs[ADDR_CONFIG_FOUR[4:0]][PDN_MSB:PDN_LSB]}),
        .q_o(cfg_s));

    function automatic logic [7:0] reg_read(input tpc_regs_t r,
                                            input logic [7:0] g,
                                            input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a <= ADDR_TX_DATA) begin
            v = r[a[4:0]];
        end else if (a == ADDR_INIT_GUARD) begin
            v = g;
        end
        return v;
    endfunction

    // ==========================================================
    // Serial slave, link domain
    // ==========================================================
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic addr_hit;

    assign scl_rise  = scl_s && !l.scl_d;
    assign scl_fall  = !scl_s && l.scl_d;
    assign bus_start = l.sda_d && !sda_s && scl_s && l.scl_d;
    assign bus_stop  = !l.sda_d && sda_s && scl_s && l.scl_d;
    assign addr_hit  = l.shreg[7:1] == SLAVE_ADDR;

    always_comb begin
        next_l       = l;
        next_l.scl_d = scl_s;
        next_l.sda_d = sda_s;
        if (lk_clr != l.clr_seen) begin
            next_l.clr_seen = lk_clr;
            next_l.txen     = 1'b0;                           // [RULE_12]
        end
        if (l.scl_d && scl_rise) begin
            next_l.bus = l.bus;
        end
        if (lk_preset) begin
            next_l.bus    = BS_IDLE;                          // [RULE_04]
            next_l.sda_oe = 1'b0;
        end else if (bus_start) begin
            // Repeated start keeps the pointer for the read phase
            next_l.bus     = BS_ADDR;                         // [RULE_17]
            next_l.bit_cnt = 4'h0;
            next_l.sda_oe  = 1'b0;
        end else if (bus_stop) begin
            next_l.bus    = BS_IDLE;                          // [RULE_03]
            next_l.sda_oe = 1'b0;
            next_l.woke   = 1'b0;
        end else begin
            case (l.bus)
                BS_ADDR, BS_REG, BS_WDATA: begin
                    if (scl_rise) begin
                        next_l.shreg   = {l.shreg[6:0], sda_s};
                        next_l.bit_cnt = l.bit_cnt + 4'h1;
                    end else if (scl_fall && l.bit_cnt == BITS_PER_BYTE) begin
                        next_l.sda_oe = 1'b1;
                        if (l.bus == BS_ADDR) begin
                            next_l.bus = addr_hit ? BS_ADDR_ACK : BS_IDLE;
                            next_l.rd  = l.shreg[0];
                            if (addr_hit && lk_sleep && !l.woke) begin
                                next_l.woke     = 1'b1;
                                next_l.wake_tgl = !l.wake_tgl; // [RULE_09]
                                if (lk_shut) begin
                                    next_l.txen = 1'b0;       // [RULE_12]
                                end
                            end
                            next_l.sda_oe = addr_hit;         // [RULE_01]
                        end else if (l.bus == BS_REG) begin
                            next_l.ptr = l.shreg;
                            next_l.bus = BS_REG_ACK;
                        end else begin
                            next_l.bus = BS_WACK;
                            if (l.ptr == ADDR_TX_DATA) begin
                                next_l.regs[l.ptr[4:0]] = l.shreg;
                                next_l.push_data = l.shreg;
                                next_l.push_tgl  = !l.push_tgl; // [RULE_13]
                            end else if ((lk_prog || l.woke) && !lk_tx) begin
                                // Asleep and not addressed: byte dropped
                                if (l.ptr == ADDR_INIT_GUARD) begin // [RULE_10]
                                    next_l.guard = l.shreg;
                                end else if (l.ptr < ADDR_TX_DATA) begin
                                    next_l.regs[l.ptr[4:0]] = l.shreg;
                                end
                                if (l.ptr == ADDR_CONFIG_SIX ||
                                    l.ptr == ADDR_CONFIG_SEVEN) begin
                                    next_l.txen = l.shreg[TXEN_BIT]; // [RULE_11]
                                end
                            end
                            if (l.ptr != ADDR_TX_DATA) begin
                                next_l.ptr = l.ptr + 8'h01;   // [RULE_13]
                            end
                        end
                    end
                end
                BS_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_l.sda_oe  = 1'b0;
                        next_l.bit_cnt = 4'h0;
                        next_l.bus     = BS_REG;
                        if (l.rd) begin
                            next_l.shreg = reg_read(l.regs, l.guard, l.ptr);
                            next_l.sda_oe = !next_l.shreg[7]; // [RULE_02]
                            next_l.bus   = BS_RDATA;
                        end
                    end
                end
                BS_REG_ACK, BS_WACK: begin
                    if (scl_fall) begin
                        next_l.sda_oe  = 1'b0;
                        next_l.bit_cnt = 4'h0;
                        next_l.bus     = BS_WDATA;
                    end
                end
                BS_RDATA: begin
                    if (scl_rise) begin
                        next_l.bit_cnt = l.bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (l.bit_cnt == BITS_PER_BYTE) begin
                            next_l.sda_oe = 1'b0;
                            next_l.bus    = BS_RACK;
                        end else begin
                            next_l.shreg  = {l.shreg[6:0], 1'b0};
                            next_l.sda_oe = !l.shreg[6];      // [RULE_02]
                        end
                    end
                end
                BS_RACK: begin
                    if (scl_rise) begin
                        // NACK drops to BS_IDLE and waits there for STOP or a new START
                        if (!sda_s) begin
                            next_l.ptr = l.ptr + 8'h01;       // [RULE_02]
                            next_l.bus = BS_ADDR_ACK;
                        end else begin
                            next_l.bus = BS_IDLE;             // [RULE_03]
                        end
                    end
                end
                default: begin
                    next_l.bus = BS_IDLE;
                end
            endcase
        end
        if (next_l.txen && !l.txen) begin
            next_l.start_tgl = !l.start_tgl;                  // [RULE_11]
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!link_rst_n) begin
            l       <= '0;
            l.bus   <= BS_IDLE;
            l.scl_d <= 1'b1;
            l.sda_d <= 1'b1;
            l.regs[ADDR_CONFIG_TWO[4:0]] <= CONFIG_TWO_RST;   // [RULE_05]
            l.guard <= INIT_GUARD_RST;
        end else begin
            l <= next_l;
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = l.sda_oe;

    // ==========================================================
    // Power states and clock output, system domain
    // ==========================================================
    logic wake_ev;
    logic start_ev;
    logic push_ev;
    logic stop_rise;

    assign wake_ev   = wake_s != c.wake_d;
    assign start_ev  = start_s != c.start_d;
    assign push_ev   = push_s != c.push_d;
    assign stop_rise = tx_stop_i && !c.stop_d;

    always_comb begin
        next_c         = c;
        next_c.data_d  = data_s;
        next_c.wake_d  = wake_s;
        next_c.start_d = start_s;
        next_c.push_d  = push_s;
        next_c.stop_d  = tx_stop_i;
        next_c.push    = 1'b0;
        next_c.idle_cnt = data_s ? 16'h0000 : c.idle_cnt + 16'h0001;
        if (preset_s) begin
            case (c.state)
                PW_SHUT: begin
                    if (data_s && !c.data_d) begin
                        next_c.state = PW_WARM;               // [RULE_06]
                    end
                end
                PW_WARM, PW_TX: begin
                    if (!data_s && c.idle_cnt == IDLE_LAST) begin
                        next_c.state = PW_SHUT;               // [RULE_07]
                    end else if (c.state == PW_WARM && lock_s &&
                                 !data_s && c.data_d) begin
                        next_c.state = PW_TX;                 // [RULE_06]
                    end
                end
                default: begin
                    next_c.state = PW_SHUT;
                end
            endcase
        end else begin
            case (c.state)
                PW_SHUT, PW_STBY: begin
                    if (wake_ev) begin
                        next_c.state = PW_PROG;               // [RULE_09]
                    end
                end
                PW_PROG: begin
                    if (start_ev) begin
                        next_c.state = PW_TX;                 // [RULE_11]
                    end
                end
                PW_TX: begin
                    if (push_ev) begin
                        next_c.push      = 1'b1;              // [RULE_23]
                        next_c.push_data = l.push_data;
                    end
                    if (stop_rise) begin                      // [RULE_24]
                        case (cfg_s[PDN_MSB:PDN_LSB])         // [RULE_14]
                            PDN_STBY: next_c.state = PW_STBY;
                            PDN_PROG: begin
                                next_c.state   = PW_PROG;     // [RULE_25]
                                next_c.clr_tgl = !c.clr_tgl;  // [RULE_12]
                            end
                            default:  next_c.state = PW_SHUT; // [RULE_18]
                        endcase
                    end
                end
                default: begin
                    next_c.state = PW_SHUT;
                end
            endcase
        end
        next_c.xo_en  = next_c.state != PW_SHUT;              // [RULE_08]
        next_c.pll_en = next_c.state == PW_WARM ||
                        next_c.state == PW_PROG || next_c.state == PW_TX;
        next_c.pa_en  = next_c.state == PW_TX;
        // Delay applies only while the pin is a clock output
        next_c.clk_oe = preset_s;                             // [RULE_04]
        if (!preset_s) begin
            next_c.dly_cnt = 7'h00;                           // [RULE_05]
            next_c.clk_cnt = 5'h00;
            next_c.buffered_clock_out  = 1'b0;
        end else if (c.dly_cnt < 7'(int'(cfg_s[3:2]) * BUFFERED_CLOCK_OUT_HALF)) begin
            next_c.dly_cnt = c.dly_cnt + 7'h01;               // [RULE_05]
        end else if (c.clk_cnt == 5'(BUFFERED_CLOCK_OUT_HALF - 1)) begin
            next_c.clk_cnt = 5'h00;
            next_c.buffered_clock_out  = !c.buffered_clock_out;                       // [RULE_04]
        end else begin
            next_c.clk_cnt = c.clk_cnt + 5'h01;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            c       <= '0;
            c.state <= PW_SHUT;                               // [RULE_06]
        end else begin
            c <= next_c;
        end
    end

    assign scl_o       = c.buffered_clock_out;
    assign scl_oe_o    = c.clk_oe;
    assign xo_en_o     = c.xo_en;
    assign pll_en_o    = c.pll_en;
    assign pa_en_o     = c.pa_en;
    assign fifo_push_o = c.push;
    assign fifo_data_o = c.push_data;

    // ==========================================================
    // Assertions
    // ==========================================================
    preset_idle_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_07]
        preset_s && c.state != PW_SHUT && !data_s && c.idle_cnt == IDLE_LAST
        |=> c.state == PW_SHUT && !xo_en_o) else $error("idle shutdown missed");
    wake_exit_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_09]
        !preset_s && (c.state == PW_SHUT || c.state == PW_STBY) && wake_ev
        |=> c.state == PW_PROG && pll_en_o) else $error("wake not taken");
    tx_start_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_11]
        !preset_s && c.state == PW_PROG && start_ev |=> pa_en_o)
        else $error("start edge ignored");
    stop_dest_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_14]
        !preset_s && c.state == PW_TX && stop_rise && cfg_s[1:0] == PDN_STBY
        |=> c.state == PW_STBY && xo_en_o && !pll_en_o)
        else $error("wrong state after stop");
    standby_power_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_08]
        c.state == PW_STBY |-> xo_en_o && !pll_en_o && !pa_en_o)
        else $error("standby enables wrong");
    push_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_23]
        fifo_push_o |-> $past(c.state) == PW_TX)
        else $error("push outside transmit");
    buffered_clock_out_mode_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_04]
        !preset_s ##1 !preset_s |-> !scl_oe_o && !scl_o)
        else $error("clock driven in bus mode");
    addr_ack_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n) // [RULE_01]
        l.bus == BS_ADDR_ACK && $past(l.bus) == BS_ADDR |-> sda_oe_o)
        else $error("address not acked");
    data_ptr_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n) // [RULE_13]
        l.ptr == ADDR_TX_DATA && l.bus != BS_REG && !l.rd
        |=> l.ptr == ADDR_TX_DATA)
        else $error("pointer left data register");
endmodule
`default_nettype wire
